// ---- hdl/lmh_host_port.sv ----
// display module host port: parallel/serial pin decoder, apb register view, and its fifo
// Operation
// R01: access only with both chip selects active
// R02: low reset pin returns settings to initial
// R03: register select high means display data
// R04: strobe style captures data on write rise
// R05: write pin is direction in enable style
// R06: strobe style drives bus while read low
// R07: read pin is high enable in style
// R08: parallel mode uses 8-bit bidirectional bus
// R09: serial uses line 7 data, 6 clock
// R10: serial mode keeps lines 0-5 released
// R11: style pin high selects enable style
// R12: mode pin high parallel, low serial
// R13: serial mode is input only, no reads
// R14: control read gives status upper, zeros lower
// R15: display data writes store, reads return byte
// R16: serial msb first, select sampled eighth bit
// R17: inactive selects ignore strobes, release bus
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps

// first-in first-out buffer with valid/ready on both sides
module lmh_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8,
    parameter int CNT_W = 4
) (
    input  wire logic             clk_sys_i,
    input  wire logic             clr_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o,
    output logic      [CNT_W-1:0] count_o
);
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];   // storage words
    logic [PTR_W-1:0] wr_ptr_q;        // write index
    logic [PTR_W-1:0] rd_ptr_q;        // read index
    logic [CNT_W-1:0] cnt_q;           // fill level
    logic             push;            // word accepted
    logic             pop;             // word handed out

    assign in_ready_o  = (cnt_q != CNT_W'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rd_ptr_q];
    assign count_o     = cnt_q;
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // storage write, no reset needed for data
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    // pointers and level
    always_ff @(posedge clk_sys_i) begin
        if (clr_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
            cnt_q <= cnt_q + CNT_W'(push) - CNT_W'(pop);
        end
    end
endmodule // lmh_fifo

// top: pin decoder of the host port plus apb slave
module lmh_host_port
    import lmh_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        sys_rst_i,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // host pins
    input  wire logic        chip_select_low_n_i,
    input  wire logic        chip_select_high_i,
    input  wire logic        reset_pin_n_i,
    input  wire logic        register_select_i,
    input  wire logic        write_strobe_i,
    input  wire logic        read_strobe_i,
    input  wire logic        bus_style_select_i,
    input  wire logic        interface_mode_pin_i,
    input  wire logic [7:0]  data_bus_lines_i,
    output logic      [7:0]  data_bus_lines_o,
    output logic      [7:0]  data_bus_lines_oe_n_o,
    output logic             rx_ready_o
);
    logic                  cs_act;      // both selects active
    logic                  par_mode;    // parallel interface chosen
    logic                  enb_style;   // direction-plus-enable style
    logic                  clr;         // settings reset
    logic                  wr_prev_q;   // previous write pin
    logic                  rd_prev_q;   // previous read pin
    logic                  scl_prev_q;  // previous serial clock
    logic [7:0]            dat_prev_q;  // previous data lines
    logic                  rs_prev_q;   // previous register select
    logic [6:0]            shift_q;     // serial shift register
    logic [2:0]            bit_cnt_q;   // serial bit counter
    logic                  push_q;      // byte ready for fifo
    logic [LMH_WORD_W-1:0] push_word_q; // {rs, byte}
    logic                  fifo_rdy;    // fifo room
    logic                  fifo_vld;    // fifo holds a byte
    logic [LMH_WORD_W-1:0] fifo_word;   // head byte
    logic [LMH_CNT_W-1:0]  fifo_cnt;    // fill level
    logic                  drive;       // bus driven toward host
    logic [7:0]            dout_q;      // byte presented on the bus
    logic [2:0]            ctrl_q;      // software status bits
    logic [7:0]            rdbyte_q;    // display byte for host reads
    logic                  acc;         // apb access completes
    logic                  pop;         // apb read of receive word
    logic                  pready_q;    // apb answer flag
    logic [31:0]           prdata_q;    // apb read data
    logic                  pslverr_q;   // apb error flag

    // mapped address check, used by the error path
    function automatic logic is_mapped(input logic [7:0] a);
        return (a == LMH_ADDR_CTRL) || (a == LMH_ADDR_RDBYTE) ||
               (a == LMH_ADDR_RXDATA) || (a == LMH_ADDR_INFO);
    endfunction

    assign cs_act    = !chip_select_low_n_i && chip_select_high_i; // [R01]
    assign par_mode  = interface_mode_pin_i;                        // [R12]
    assign enb_style = bus_style_select_i;                          // [R11]
    assign clr       = sys_rst_i || !reset_pin_n_i;                 // [R02]

    // pin history for edge detection
    always_ff @(posedge clk_sys_i) begin
        if (clr) begin
            wr_prev_q  <= 1'b1;
            rd_prev_q  <= 1'b0;
            scl_prev_q <= 1'b0;
            dat_prev_q <= 8'h00;
            rs_prev_q  <= 1'b0;
        end else begin
            wr_prev_q  <= write_strobe_i;
            rd_prev_q  <= read_strobe_i;
            scl_prev_q <= data_bus_lines_i[LMH_SCL_BIT];
            dat_prev_q <= data_bus_lines_i;
            rs_prev_q  <= register_select_i;
        end
    end

    // serial shifter: msb first on clock rise, select taken with bit eight
    always_ff @(posedge clk_sys_i) begin
        if (clr || par_mode || !cs_act) begin // [R17]
            shift_q   <= 7'h00;
            bit_cnt_q <= 3'h0;
        end else if (data_bus_lines_i[LMH_SCL_BIT] && !scl_prev_q) begin // [R09]
            shift_q   <= {shift_q[5:0], data_bus_lines_i[LMH_SI_BIT]};    // [R16]
            bit_cnt_q <= bit_cnt_q + 3'h1;
        end
    end

    // byte capture from all three access styles
    always_ff @(posedge clk_sys_i) begin
        if (clr) begin
            push_q      <= 1'b0;
            push_word_q <= '0;
        end else begin
            push_q <= 1'b0;
            if (cs_act) begin // [R01]
                if (!par_mode) begin
                    // serial byte completes on the eighth rising clock
                    if (data_bus_lines_i[LMH_SCL_BIT] && !scl_prev_q &&
                        bit_cnt_q == LMH_SER_LAST) begin
                        push_q      <= 1'b1;
                        push_word_q <= {register_select_i, shift_q,
                                        data_bus_lines_i[LMH_SI_BIT]}; // [R16] [R03]
                    end
                end else if (!enb_style) begin
                    // strobe style: latch on write pin rise
                    if (write_strobe_i && !wr_prev_q) begin // [R04]
                        push_q      <= 1'b1;
                        push_word_q <= {rs_prev_q, dat_prev_q}; // [R03] [R15]
                    end
                end else begin
                    // enable style: write when enable falls with direction low
                    if (!read_strobe_i && rd_prev_q && !wr_prev_q) begin // [R05] [R07]
                        push_q      <= 1'b1;
                        push_word_q <= {rs_prev_q, dat_prev_q}; // [R03] [R15]
                    end
                end
            end
        end
    end

    // read drive window, parallel only
    always_comb begin
        drive = 1'b0;
        if (cs_act && par_mode) begin // [R13] [R17]
            if (enb_style) begin
                drive = read_strobe_i && write_strobe_i; // [R07] [R05]
            end else begin
                drive = !read_strobe_i; // [R06]
            end
        end
    end

    // output enables: serial leaves every line released
    assign data_bus_lines_oe_n_o = drive ? 8'h00 : 8'hFF; // [R08] [R10]
    assign data_bus_lines_o      = dout_q;

    // byte offered to the host: status nibble or display byte
    always_ff @(posedge clk_sys_i) begin
        if (clr) begin
            dout_q <= 8'h00;
        end else if (register_select_i) begin
            dout_q <= rdbyte_q; // [R15]
        end else begin
            dout_q <= {!fifo_rdy, ctrl_q, 4'h0}; // [R14]
        end
    end

    // receive buffer, drained by software
    lmh_fifo #(
        .WIDTH (LMH_WORD_W),
        .DEPTH (LMH_FIFO_D),
        .CNT_W (LMH_CNT_W)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .clr_i       (clr),
        .in_valid_i  (push_q),
        .in_ready_o  (fifo_rdy),
        .in_data_i   (push_word_q),
        .out_valid_o (fifo_vld),
        .out_ready_i (pop),
        .out_data_o  (fifo_word),
        .count_o     (fifo_cnt)
    );
    assign rx_ready_o = fifo_rdy;

    assign acc = psel && penable && pready_q;
    assign pop = acc && !pwrite && (paddr == LMH_ADDR_RXDATA);

    // apb answer: one wait state, read data latched then
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (psel && penable && !pready_q) begin
            pready_q  <= 1'b1;
            pslverr_q <= !is_mapped(paddr);
            prdata_q  <= 32'h0000_0000;
            if (!pwrite) begin
                case (paddr)
                    LMH_ADDR_CTRL:   prdata_q <= {29'h0, ctrl_q};
                    LMH_ADDR_RDBYTE: prdata_q <= {24'h0, rdbyte_q};
                    LMH_ADDR_RXDATA: prdata_q <= {22'h0, fifo_vld, fifo_word};
                    LMH_ADDR_INFO:   prdata_q <= {24'h0, par_mode, enb_style,
                                                  !fifo_rdy, !fifo_vld, fifo_cnt};
                    default:         prdata_q <= 32'h0000_0000;
                endcase
            end
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end
    assign pready  = pready_q;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;

    // software settings, also cleared by the reset pin
    always_ff @(posedge clk_sys_i) begin
        if (clr) begin // [R02]
            ctrl_q   <= LMH_CTRL_RST;
            rdbyte_q <= LMH_RDBYTE_RST;
        end else if (acc && pwrite) begin
            if (paddr == LMH_ADDR_CTRL) begin
                ctrl_q <= pwdata[LMH_CTRL_STAT_MSB:LMH_CTRL_STAT_LSB];
            end
            if (paddr == LMH_ADDR_RDBYTE) begin
                rdbyte_q <= pwdata[7:0];
            end
        end
    end

    // strobe-style write edge with selects active
    sequence s_wr_rise;
        cs_act && par_mode && !enb_style && write_strobe_i && !wr_prev_q;
    endsequence
    // enable-style write edge with selects active
    sequence s_en_fall;
        cs_act && par_mode && enb_style && !read_strobe_i && rd_prev_q && !wr_prev_q;
    endsequence

    property p_cs_gate;
        @(posedge clk_sys_i) disable iff (clr) !cs_act |=> !push_q;
    endproperty
    a_cs_gate: assert property (p_cs_gate) else $error("byte taken without select"); // [R01]

    property p_reset;
        @(posedge clk_sys_i) !reset_pin_n_i |=> (fifo_cnt == '0) && (ctrl_q == LMH_CTRL_RST);
    endproperty
    a_reset: assert property (p_reset) else $error("reset pin left settings"); // [R02]

    property p_wr_capture;
        @(posedge clk_sys_i) disable iff (clr)
            s_wr_rise |=> push_q && push_word_q == {$past(rs_prev_q), $past(dat_prev_q)};
    endproperty
    a_wr_capture: assert property (p_wr_capture) else $error("write rise not latched"); // [R04]

    property p_en_capture;
        @(posedge clk_sys_i) disable iff (clr)
            s_en_fall |=> push_q && push_word_q[LMH_RX_RS_BIT] == $past(rs_prev_q);
    endproperty
    a_en_capture: assert property (p_en_capture) else $error("enable write missed"); // [R05]

    property p_strobe_drive;
        @(posedge clk_sys_i) disable iff (clr)
            cs_act && par_mode && !enb_style |-> (data_bus_lines_oe_n_o == 8'h00) == !read_strobe_i;
    endproperty
    a_strobe_drive: assert property (p_strobe_drive) else $error("read drive wrong"); // [R06]

    property p_enable_drive;
        @(posedge clk_sys_i) disable iff (clr)
            cs_act && par_mode && enb_style && read_strobe_i && write_strobe_i
            |-> data_bus_lines_oe_n_o == 8'h00;
    endproperty
    a_enable_drive: assert property (p_enable_drive) else $error("enable read not driven"); // [R07]

    property p_serial_release;
        @(posedge clk_sys_i) disable iff (clr) !par_mode |-> data_bus_lines_oe_n_o == 8'hFF;
    endproperty
    a_serial_release: assert property (p_serial_release) else $error("serial drove bus"); // [R10]

    property p_idle_release;
        @(posedge clk_sys_i) disable iff (clr) !cs_act |-> data_bus_lines_oe_n_o == 8'hFF;
    endproperty
    a_idle_release: assert property (p_idle_release) else $error("bus driven unselected"); // [R17]

    property p_status_low;
        @(posedge clk_sys_i) disable iff (clr)
            !register_select_i ##1 !register_select_i |-> dout_q[3:0] == 4'h0;
    endproperty
    a_status_low: assert property (p_status_low) else $error("status low nibble set"); // [R14]

    property p_serial_byte;
        @(posedge clk_sys_i) disable iff (clr)
            !par_mode && cs_act && bit_cnt_q == LMH_SER_LAST && !scl_prev_q
            && data_bus_lines_i[LMH_SCL_BIT]
            |=> push_q && push_word_q[0] == $past(data_bus_lines_i[LMH_SI_BIT]);
    endproperty
    a_serial_byte: assert property (p_serial_byte) else $error("serial byte lost"); // [R16]
endmodule // lmh_host_port

// ---- hdl/lmh_pkg.sv ----
// package of constants for the display module host port
package lmh_pkg;
    // apb register byte offsets
    localparam logic [7:0] LMH_ADDR_CTRL   = 8'h00; // software status bits
    localparam logic [7:0] LMH_ADDR_RDBYTE = 8'h04; // display byte returned on reads
    localparam logic [7:0] LMH_ADDR_RXDATA = 8'h08; // received byte, read pops
    localparam logic [7:0] LMH_ADDR_INFO   = 8'h0C; // fifo level and pin view
    // control register field positions
    localparam int LMH_CTRL_STAT_LSB = 0;  // three software status bits
    localparam int LMH_CTRL_STAT_MSB = 2;
    // reset values
    localparam logic [2:0] LMH_CTRL_RST   = 3'h0;
    localparam logic [7:0] LMH_RDBYTE_RST = 8'h00;
    // received word layout: {valid, register_select, byte}
    localparam int LMH_RX_VALID_BIT = 9;
    localparam int LMH_RX_RS_BIT    = 8;
    // info register field positions
    localparam int LMH_INFO_EMPTY_BIT = 4;
    localparam int LMH_INFO_FULL_BIT  = 5;
    localparam int LMH_INFO_STYLE_BIT = 6;
    localparam int LMH_INFO_MODE_BIT  = 7;
    // bus widths and fifo shape
    localparam int LMH_DATA_W   = 8;
    localparam int LMH_WORD_W   = 9;
    localparam int LMH_FIFO_D   = 8;
    localparam int LMH_CNT_W    = 4;
    localparam logic [2:0] LMH_SER_LAST = 3'h7; // eighth serial bit index
    // serial data and clock lines
    localparam int LMH_SI_BIT  = 7;
    localparam int LMH_SCL_BIT = 6;
endpackage

// ---- verif/lmh_host_model.sv ----
// host microprocessor model that drives the display port pins
`timescale 1ns/1ps

module lmh_host_model (
    input  wire logic       clk_sys_i,
    input  wire logic [7:0] dq_seen_i,   // resolved data lines
    input  wire logic [7:0] oe_n_seen_i, // device output enables
    output logic            cs_n_o,
    output logic            cs_o,
    output logic            rs_o,
    output logic            wr_o,
    output logic            rd_o,
    output logic            style_o,
    output logic            mode_o,
    output logic      [7:0] dq_o
);
    // idle pins at time zero: deselected, strobe style, parallel
    initial begin
        cs_n_o  = 1'h1;
        cs_o    = 1'h0;
        rs_o    = 1'h0;
        wr_o    = 1'h1;
        rd_o    = 1'h1;
        style_o = 1'h0;
        mode_o  = 1'h1;
        dq_o    = 8'h00;
    end

    // both selects move together for an access, or both drop
    task automatic sel(input logic on);
        cs_n_o <= ~on;
        cs_o   <= on;
    endtask

    // bus style and interface mode, strobes back to their idle level
    task automatic set_mode(input logic s, input logic m);
        style_o <= s;
        mode_o  <= m;
        wr_o    <= 1'h1;
        rd_o    <= ~s;
    endtask

    // one byte to the device in the current style and mode
    task automatic put(input logic r, input logic [7:0] b);
        int i;
        rs_o <= r;
        if (!mode_o) begin
            // serial: msb first, data on line 7, clock on line 6
            for (i = 7; i >= 0; i--) begin
                dq_o <= {b[i], 1'h0, ~dq_o[5:0]};
                repeat (2) @(posedge clk_sys_i);
                dq_o[6] <= 1'h1;
                repeat (2) @(posedge clk_sys_i);
            end
        end else if (!style_o) begin
            // low write strobe, byte taken when it rises
            dq_o <= b;
            wr_o <= 1'h0;
            repeat (2) @(posedge clk_sys_i);
            wr_o <= 1'h1;
            repeat (2) @(posedge clk_sys_i);
        end else begin
            // direction low means write, enable frames it
            dq_o <= b;
            wr_o <= 1'h0;
            rd_o <= 1'h1;
            repeat (2) @(posedge clk_sys_i);
            rd_o <= 1'h0;
            repeat (2) @(posedge clk_sys_i);
            wr_o <= 1'h1;
        end
        // lines released: inverse of the last byte, serial clock parked low
        dq_o <= mode_o ? ~b : {~b[7], 1'h0, ~b[5:0]};
        repeat (2) @(posedge clk_sys_i);
    endtask

    // one read window; returns the line level and the enables
    task automatic get(input logic r, output logic [7:0] v, output logic [7:0] oe);
        rs_o <= r;
        wr_o <= 1'h1;
        rd_o <= style_o;
        repeat (3) @(posedge clk_sys_i);
        v  = dq_seen_i;
        oe = oe_n_seen_i;
        rd_o <= ~style_o;
        repeat (2) @(posedge clk_sys_i);
    endtask
endmodule // lmh_host_model

// ---- verif/lcd_module_host_interface_bench.sv ----
// self-checking bench of the host port: table of transfers, then hand tests
`timescale 1ns/1ps

module lcd_module_host_interface_bench
    import lmh_pkg::*;
;
    logic        clk_sys_i, sys_rst_i, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        pin_rst_n, cs_n, cs, rs, wr, rd, style, mode, rx_ready;
    logic [7:0]  host_dq, dut_dq, oe_n, bus_w, v, oe;
    logic [31:0] d;
    logic        e;
    int          err_count, n_compared, i;
    // rows: {kind 0 strobe / 1 enable / 2 serial, register select, byte}
    logic [10:0] rows [6] = '{11'h1A5, 11'h03C, 11'h381, 11'h27E, 11'h5C3, 11'h401};

    // each line carries the device value while it drives, else the host value
    assign bus_w = (~oe_n & dut_dq) | (oe_n & host_dq);

    lmh_host_port dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .chip_select_low_n_i(cs_n), .chip_select_high_i(cs), .reset_pin_n_i(pin_rst_n),
        .register_select_i(rs), .write_strobe_i(wr), .read_strobe_i(rd),
        .bus_style_select_i(style), .interface_mode_pin_i(mode),
        .data_bus_lines_i(bus_w), .data_bus_lines_o(dut_dq),
        .data_bus_lines_oe_n_o(oe_n), .rx_ready_o(rx_ready));

    lmh_host_model hm (.clk_sys_i(clk_sys_i), .dq_seen_i(bus_w), .oe_n_seen_i(oe_n),
        .cs_n_o(cs_n), .cs_o(cs), .rs_o(rs), .wr_o(wr), .rd_o(rd), .style_o(style),
        .mode_o(mode), .dq_o(host_dq));

    // 100 MHz clock
    initial begin
        clk_sys_i = 1'h0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // compare one value, count it, report a mismatch at once
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    // one apb transfer: setup, access held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rdat, output logic er);
        int n;
        n = 0;
        psel    <= 1'h1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk_sys_i);
        penable <= 1'h1;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready !== 1'h1);
        rdat = prdata;
        er   = pslverr;
        check("apb_wait", 32'h2, n);
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge clk_sys_i);
    endtask

    // the one place where the run ends
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        #200000;
        err_count++;
        end_sim();
    end

    // main sequence
    initial begin
        err_count = 0;
        n_compared = 0;
        sys_rst_i = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pin_rst_n = 1'h1;
        repeat (2) @(posedge clk_sys_i);
        sys_rst_i <= 1'h0;
        @(posedge clk_sys_i);
        // reset values and an unmapped place
        apb(1'h0, LMH_ADDR_CTRL, 32'h0, d, e);
        check("ctrl_rst", 32'h0, d);
        apb(1'h0, LMH_ADDR_RDBYTE, 32'h0, d, e);
        check("rdbyte_rst", 32'h0, d);
        apb(1'h0, LMH_ADDR_INFO, 32'h0, d, e);
        check("info_rst", 32'h90, d);
        apb(1'h0, 8'h10, 32'h0, d, e);
        check("unmapped_rd", 32'h8000_0000, {e, d[30:0]});
        apb(1'h1, 8'h10, 32'hFF, d, e);
        check("unmapped_wr", 32'h1, {31'h0, e});
        hm.sel(1'h1);
        @(posedge clk_sys_i);
        // table of transfers through every style and mode
        for (i = 0; i < 6; i++) begin
            hm.set_mode(rows[i][10:9] == 2'h1, rows[i][10:9] != 2'h2);
            @(posedge clk_sys_i);
            hm.put(rows[i][8], rows[i][7:0]);
            apb(1'h0, LMH_ADDR_RXDATA, 32'h0, d, e);
            check("rx_word", {22'h0, 1'h1, rows[i][8:0]}, d);
            apb(1'h0, LMH_ADDR_INFO, 32'h0, d, e);
            check("info_pins", {24'h0, rows[i][10:9] != 2'h2, rows[i][10:9] == 2'h1, 6'h10}, d);
        end
        // parallel reads of status and display data
        hm.set_mode(1'h0, 1'h1);
        apb(1'h1, LMH_ADDR_CTRL, 32'h5, d, e);
        apb(1'h1, LMH_ADDR_RDBYTE, 32'hA5, d, e);
        check("oe_idle", 32'hFF, {24'h0, oe_n});
        hm.get(1'h0, v, oe);
        check("status_rd", 32'h0050, {16'h0, oe, v});
        hm.get(1'h1, v, oe);
        check("data_rd", 32'h00A5, {16'h0, oe, v});
        hm.set_mode(1'h1, 1'h1);
        @(posedge clk_sys_i);
        hm.get(1'h1, v, oe);
        check("enable_rd", 32'h00A5, {16'h0, oe, v});
        // serial mode never drives, even with the read strobe low
        hm.set_mode(1'h0, 1'h0);
        @(posedge clk_sys_i);
        hm.get(1'h0, v, oe);
        check("serial_oe", 32'hFF, {24'h0, oe});
        // selects inactive: strobes ignored, lines released
        hm.set_mode(1'h0, 1'h1);
        hm.sel(1'h0);
        @(posedge clk_sys_i);
        hm.put(1'h1, 8'h66);
        hm.get(1'h0, v, oe);
        check("desel_oe", 32'hFF, {24'h0, oe});
        apb(1'h0, LMH_ADDR_INFO, 32'h0, d, e);
        check("desel_empty", 32'h90, d);
        hm.sel(1'h1);
        @(posedge clk_sys_i);
        // fill the buffer past its depth, then drain it
        for (i = 0; i < 9; i++) hm.put(1'h1, 8'h10 + 8'(i));
        apb(1'h0, LMH_ADDR_INFO, 32'h0, d, e);
        check("info_full", 32'hA8, d);
        check("rx_ready_full", 32'h0, {31'h0, rx_ready});
        hm.get(1'h0, v, oe);
        check("status_busy", 32'h00D0, {16'h0, oe, v});
        for (i = 0; i < 9; i++) begin
            apb(1'h0, LMH_ADDR_RXDATA, 32'h0, d, e);
            check("drain", (i < 8) ? 32'h310 + i : 32'h0, (i < 8) ? d : {22'h0, d[9], 9'h0});
        end
        check("rx_ready_empty", 32'h1, {31'h0, rx_ready});
        // reset pin low returns settings and buffer to initial
        hm.put(1'h1, 8'h5A);
        pin_rst_n <= 1'h0;
        repeat (2) @(posedge clk_sys_i);
        pin_rst_n <= 1'h1;
        @(posedge clk_sys_i);
        apb(1'h0, LMH_ADDR_CTRL, 32'h0, d, e);
        check("pin_rst_ctrl", 32'h0, d);
        apb(1'h0, LMH_ADDR_INFO, 32'h0, d, e);
        check("pin_rst_info", 32'h90, d);
        end_sim();
    end
endmodule // lcd_module_host_interface_bench
